// [inc/diag_wdt_pkg.sv]
// Constants and helpers shared by the diagnostic watchdog register bank
package diag_wdt_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [5:0] OFS_WATCHDOG_CONTROL = 6'h11;
  localparam logic [5:0] OFS_INPUT0_LIMITS    = 6'h12;
  localparam logic [5:0] OFS_INPUT1_LIMITS    = 6'h13;
  localparam logic [5:0] OFS_DIE_TEMP_LIMITS  = 6'h14;
  localparam logic [5:0] OFS_ACCESS_PORT_SEL  = 6'h16;
  localparam logic [5:0] OFS_INVERT_SCRATCH   = 6'h18;
  localparam logic [5:0] OFS_LOT_ID_LOW       = 6'h19;

  // ==========================================================
  // Field positions
  localparam int unsigned WDT_ON_BIT    = 0;
  localparam int unsigned WATCHDOG_LOWER_BOUND_LSB    = 1;
  localparam int unsigned WATCHDOG_LOWER_BOUND_MSB    = 2;
  localparam int unsigned WATCHDOG_UPPER_BOUND_LSB    = 3;
  localparam int unsigned WATCHDOG_UPPER_BOUND_MSB    = 5;
  localparam int unsigned LIM_LO_LSB    = 0;
  localparam int unsigned LIM_LO_MSB    = 7;
  localparam int unsigned LIM_HI_LSB    = 8;
  localparam int unsigned LIM_HI_MSB    = 15;
  localparam int unsigned UART_MODE_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_WATCHDOG_CONTROL = 16'h0018;
  localparam logic [15:0] RST_LIMITS           = 16'hFF00;
  localparam logic [15:0] RST_ACCESS_PORT_SEL  = 16'h0000;
  localparam logic [15:0] RST_INVERT_SCRATCH   = 16'hFFFF;

  // ==========================================================
  // Timing: 125 MHz system clock, 1.2288 MHz oscillator, /1024 tick
  localparam logic [31:0] CLK_HZ     = 32'h0773_5940;
  localparam logic [31:0] OSC_HZ     = 32'h0012_C000;
  localparam logic [10:0] TICK_DIV   = 11'h400;
  localparam int unsigned TICK_W     = 13;
  localparam logic [1:0]  LOT_ID_SETTLE = 2'h3;

  // ==========================================================
  // Fault actions and ADC channel codes
  typedef enum logic [1:0] {
    ACT_NONE, ACT_DAC_CLEAR, ACT_ALARM_V, ACT_DAC_HIZ
  } fault_action_t;
  localparam logic [1:0] CH_INPUT0 = 2'h0;
  localparam logic [1:0] CH_INPUT1 = 2'h1;
  localparam logic [1:0] CH_TEMP   = 2'h2;

  // Upper window bound in ticks
  function automatic logic [TICK_W-1:0] upper_ticks(input logic [2:0] code);
    case (code)
      3'h0:    upper_ticks = 13'h0040;
      3'h1:    upper_ticks = 13'h0080;
      3'h2:    upper_ticks = 13'h0200;
      3'h3:    upper_ticks = 13'h0400;
      3'h4:    upper_ticks = 13'h0800;
      3'h5:    upper_ticks = 13'h0C00;
      3'h6:    upper_ticks = 13'h1000;
      default: upper_ticks = 13'h1800;
    endcase
  endfunction : upper_ticks

  // Lower window bound in ticks; zero means disabled
  function automatic logic [TICK_W-1:0] lower_ticks(input logic [1:0] code);
    case (code)
      2'h1:    lower_ticks = 13'h0040;
      2'h2:    lower_ticks = 13'h0080;
      2'h3:    lower_ticks = 13'h0200;
      default: lower_ticks = 13'h0000;
    endcase
  endfunction : lower_ticks

  // Stronger of two fault actions
  function automatic logic [1:0] act_max(input logic [1:0] a, input logic [1:0] b);
    act_max = (a > b) ? a : b;
  endfunction : act_max

endpackage : diag_wdt_pkg

// [hw/wdt_tick_divider.sv]
// Watchdog tick generator: system clock to oscillator rate, then divide by 1024
`timescale 1ns/100ps
module wdt_tick_divider (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Tick enable
  output logic      tick_o
);
  import diag_wdt_pkg::*;

  logic [31:0] phase;
  logic [9:0]  osc_cnt;
  logic        osc_en;

  // ==========================================================
  // Fractional accumulator: one pulse per oscillator period on average
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase  <= 32'h0000_0000;
      osc_en <= 1'b0;
    end else if (phase + OSC_HZ >= CLK_HZ) begin
      phase  <= phase + OSC_HZ - CLK_HZ;
      osc_en <= 1'b1;
    end else begin
      phase  <= phase + OSC_HZ;
      osc_en <= 1'b0;
    end
  end

  // ==========================================================
  // Divide oscillator pulses by 1024
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_cnt <= 10'h000;
      tick_o  <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (osc_en) begin
        osc_cnt <= osc_cnt + 10'h001;
        tick_o  <= (osc_cnt == 10'(TICK_DIV - 11'h001));
      end
    end
  end

endmodule : wdt_tick_divider

// [hw/limit_checker.sv]
// Expanded high/low threshold comparison for one ADC channel
`timescale 1ns/100ps
module limit_checker (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // New conversion result
  input  wire logic        done_i,
  input  wire logic [11:0] data_i,
  // Threshold register
  input  wire logic [15:0] limits_i,
  // Violation flags, held until next result
  output logic             above_o,
  output logic             below_o
);
  import diag_wdt_pkg::*;

  logic [11:0] hi_lim;
  logic [11:0] lo_lim;

  assign hi_lim = {limits_i[LIM_HI_MSB:LIM_HI_LSB], 4'hF};
  assign lo_lim = {limits_i[LIM_LO_MSB:LIM_LO_LSB], 4'h0};

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      above_o <= 1'b0;
      below_o <= 1'b0;
    end else if (done_i) begin
      above_o <= (data_i > hi_lim);
      below_o <= (data_i < lo_lim);
    end
  end

endmodule : limit_checker

// [hw/diag_watchdog_register_bank.sv]
// Watchdog, threshold, access-select, scratch and lot id register bank
`timescale 1ns/100ps
module diag_watchdog_register_bank (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Register access from serial front ends
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_from_uart_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  // Lot identity strap
  input  wire logic [15:0] lot_id_i,
  // ADC results
  input  wire logic        adc_done_i,
  input  wire logic [1:0]  adc_chan_i,
  input  wire logic [11:0] adc_data_i,
  // Fault configuration from the alarm registers
  input  wire logic [1:0]  link_fault_action_i,
  input  wire logic [1:0]  input0_action_i,
  input  wire logic [1:0]  input1_action_i,
  input  wire logic [1:0]  temp_action_i,
  input  wire logic        timeout_fault_mask_i,
  input  wire logic        link_crc_error_i,
  input  wire logic        status_clear_i,
  // Fault status and action
  output logic             watchdog_status_o,
  output logic             crc_status_o,
  output logic             watchdog_timeout_o,
  output logic [5:0]       limit_status_o,
  output logic             uart_break_access_o,
  output diag_wdt_pkg::fault_action_t fault_action_o,
  output logic             alarm_trigger_o
);
  import diag_wdt_pkg::*;

  // ==========================================================
  // Registers and internal signals
  logic [2:0]        watchdog_upper_bound;
  logic [1:0]        watchdog_lower_bound;
  logic              watchdog_on;
  logic [15:0]       input0_limits;
  logic [15:0]       input1_limits;
  logic [15:0]       die_temp_limits;
  logic              uart_break_access;
  logic [15:0]       inverting_scratch;
  logic [15:0]       lot_unique_id_low;
  logic [15:0]       lot_id_meta;
  logic [15:0]       lot_id_sync;
  logic [1:0]        lot_id_wait;
  logic [TICK_W-1:0] wdt_count;
  logic              tick;
  logic              port_ok;
  logic              wr_ok;
  logic              wr_wdt;
  logic              wr_in0;
  logic              wr_in1;
  logic              wr_temp;
  logic              wr_inv;
  logic              service;
  logic              windowed;
  logic              early;
  logic              late;
  logic              next_timeout;
  logic [5:0]        viol;
  logic [15:0]       next_rdata;
  logic [1:0]        next_action;

  // ==========================================================
  // Access gating
  // The mode register is always readable but written only from UART; the rest only from the chosen port
  assign port_ok  = (reg_from_uart_i == uart_break_access);
  assign wr_ok    = reg_wr_i && port_ok;
  assign wr_wdt   = wr_ok && (reg_addr_i == OFS_WATCHDOG_CONTROL);
  assign wr_in0   = wr_ok && (reg_addr_i == OFS_INPUT0_LIMITS);
  assign wr_in1   = wr_ok && (reg_addr_i == OFS_INPUT1_LIMITS);
  assign wr_temp  = wr_ok && (reg_addr_i == OFS_DIE_TEMP_LIMITS);
  assign wr_inv   = wr_ok && (reg_addr_i == OFS_INVERT_SCRATCH);
  assign windowed = (watchdog_lower_bound != 2'h0);
  // Any accepted write services unless the window is on
  assign service  = windowed ? wr_wdt : wr_ok;

  // ==========================================================
  // Watchdog control register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watchdog_upper_bound <= RST_WATCHDOG_CONTROL[WATCHDOG_UPPER_BOUND_MSB:WATCHDOG_UPPER_BOUND_LSB];
      watchdog_lower_bound <= RST_WATCHDOG_CONTROL[WATCHDOG_LOWER_BOUND_MSB:WATCHDOG_LOWER_BOUND_LSB];
      watchdog_on          <= RST_WATCHDOG_CONTROL[WDT_ON_BIT];
    end else if (wr_wdt) begin
      watchdog_upper_bound <= reg_wdata_i[WATCHDOG_UPPER_BOUND_MSB:WATCHDOG_UPPER_BOUND_LSB];
      watchdog_lower_bound <= reg_wdata_i[WATCHDOG_LOWER_BOUND_MSB:WATCHDOG_LOWER_BOUND_LSB];
      watchdog_on          <= reg_wdata_i[WDT_ON_BIT];
    end
  end

  // ==========================================================
  // Threshold registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      input0_limits   <= RST_LIMITS;
      input1_limits   <= RST_LIMITS;
      die_temp_limits <= RST_LIMITS;
    end else begin
      if (wr_in0) begin
        input0_limits <= reg_wdata_i;
      end
      if (wr_in1) begin
        input1_limits <= reg_wdata_i;
      end
      if (wr_temp) begin
        die_temp_limits <= reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // Access port select: UART break writes only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uart_break_access <= RST_ACCESS_PORT_SEL[UART_MODE_BIT];
    end else if (reg_wr_i && reg_from_uart_i && (reg_addr_i == OFS_ACCESS_PORT_SEL)) begin
      uart_break_access <= reg_wdata_i[UART_MODE_BIT];
    end
  end

  // ==========================================================
  // Inverting scratch, stored already inverted
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inverting_scratch <= RST_INVERT_SCRATCH;
    end else if (wr_inv) begin
      inverting_scratch <= ~reg_wdata_i;
    end
  end

  // ==========================================================
  // Lot id strap: two flops before any use
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lot_id_meta <= 16'h0000;
      lot_id_sync <= 16'h0000;
    end else begin
      lot_id_meta <= lot_id_i;
      lot_id_sync <= lot_id_meta;
    end
  end

  // ==========================================================
  // Lot id captured once the strap has settled; never written
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lot_unique_id_low <= 16'h0000;
      lot_id_wait       <= 2'h0;
    end else if (lot_id_wait != LOT_ID_SETTLE) begin
      // Reloads until the synchroniser holds the strap
      lot_unique_id_low <= lot_id_sync;
      lot_id_wait       <= lot_id_wait + 2'h1;
    end
  end

  // ==========================================================
  // Watchdog timer
  wdt_tick_divider u_tick (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  assign late  = (wdt_count > upper_ticks(watchdog_upper_bound));
  assign early = (wdt_count < lower_ticks(watchdog_lower_bound));
  assign next_timeout = watchdog_on && (late || (windowed && wr_wdt && early));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdt_count <= '0;
    end else if (!watchdog_on || service || next_timeout) begin
      // Restart after a service or after an error so errors repeat per period
      wdt_count <= '0;
    end else if (tick) begin
      wdt_count <= wdt_count + 13'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watchdog_timeout_o <= 1'b0;
    end else begin
      watchdog_timeout_o <= next_timeout;
    end
  end

  // ==========================================================
  // Sticky status flags; a new event wins over a clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      watchdog_status_o <= 1'b0;
      crc_status_o      <= 1'b0;
    end else begin
      watchdog_status_o <= next_timeout || (watchdog_status_o && !status_clear_i);
      crc_status_o      <= link_crc_error_i || (crc_status_o && !status_clear_i);
    end
  end

  // ==========================================================
  // Threshold checks per channel
  limit_checker u_in0 (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .done_i   (adc_done_i && (adc_chan_i == CH_INPUT0)),
    .data_i   (adc_data_i),
    .limits_i (input0_limits),
    .above_o  (viol[0]),
    .below_o  (viol[1])
  );

  limit_checker u_in1 (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .done_i   (adc_done_i && (adc_chan_i == CH_INPUT1)),
    .data_i   (adc_data_i),
    .limits_i (input1_limits),
    .above_o  (viol[2]),
    .below_o  (viol[3])
  );

  limit_checker u_temp (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .done_i   (adc_done_i && (adc_chan_i == CH_TEMP)),
    .data_i   (adc_data_i),
    .limits_i (die_temp_limits),
    .above_o  (viol[4]),
    .below_o  (viol[5])
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      limit_status_o <= 6'h00;
    end else begin
      limit_status_o <= viol;
    end
  end

  // ==========================================================
  // Fault action: strongest request among active faults
  always_comb begin
    next_action = ACT_NONE;
    if (!timeout_fault_mask_i && watchdog_status_o) begin
      next_action = act_max(next_action, link_fault_action_i);
    end
    if (crc_status_o) begin
      next_action = act_max(next_action, link_fault_action_i);
    end
    if (viol[1:0] != 2'h0) begin
      next_action = act_max(next_action, input0_action_i);
    end
    if (viol[3:2] != 2'h0) begin
      next_action = act_max(next_action, input1_action_i);
    end
    if (viol[5:4] != 2'h0) begin
      next_action = act_max(next_action, temp_action_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_action_o  <= ACT_NONE;
      alarm_trigger_o <= 1'b0;
    end else begin
      fault_action_o  <= fault_action_t'(next_action);
      alarm_trigger_o <= (next_action != ACT_NONE);
    end
  end

  // ==========================================================
  // Read path: one cycle after the request
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr_i == OFS_ACCESS_PORT_SEL) begin
      next_rdata[UART_MODE_BIT] = uart_break_access;
    end else if (port_ok) begin
      case (reg_addr_i)
        OFS_WATCHDOG_CONTROL: begin
          next_rdata[WATCHDOG_UPPER_BOUND_MSB:WATCHDOG_UPPER_BOUND_LSB] = watchdog_upper_bound;
          next_rdata[WATCHDOG_LOWER_BOUND_MSB:WATCHDOG_LOWER_BOUND_LSB] = watchdog_lower_bound;
          next_rdata[WDT_ON_BIT]            = watchdog_on;
        end
        OFS_INPUT0_LIMITS:   next_rdata = input0_limits;
        OFS_INPUT1_LIMITS:   next_rdata = input1_limits;
        OFS_DIE_TEMP_LIMITS: next_rdata = die_temp_limits;
        OFS_INVERT_SCRATCH:  next_rdata = inverting_scratch;
        OFS_LOT_ID_LOW:      next_rdata = lot_unique_id_low;
        default:             next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uart_break_access_o <= 1'b0;
    end else begin
      uart_break_access_o <= uart_break_access;
    end
  end

endmodule : diag_watchdog_register_bank

// [tb/diag_wdt_checker_assertions.sv]
// Port-level checks for the diagnostic watchdog register bank
`timescale 1ns/100ps
module diag_wdt_checker (
  // Clock, reset and register bus
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic                          reg_from_uart_i,
  input  wire logic [5:0]                    reg_addr_i,
  input  wire logic [15:0]                   reg_wdata_i,
  input  wire logic [15:0]                   reg_rdata_o,
  input  wire logic                          reg_rvalid_o,
  input  wire logic [15:0]                   lot_id_i,
  // Events and status
  input  wire logic                          adc_done_i,
  input  wire logic                          link_crc_error_i,
  input  wire logic                          status_clear_i,
  input  wire logic                          watchdog_status_o,
  input  wire logic                          crc_status_o,
  input  wire logic                          watchdog_timeout_o,
  input  wire logic [5:0]                    limit_status_o,
  input  wire logic                          uart_break_access_o,
  input  wire logic [1:0]                    fault_action_o,
  input  wire logic                          alarm_trigger_o
);
  import diag_wdt_pkg::*;
  // ==========================================================
  // Helper state
  logic port_ok;
  logic wdt_on;
  assign port_ok = reg_from_uart_i == uart_break_access_o;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wdt_on <= 1'b0;
    else if (reg_wr_i && port_ok && reg_addr_i == OFS_WATCHDOG_CONTROL) wdt_on <= reg_wdata_i[0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Assertions
  a_read_answer: assert property (
    reg_rvalid_o == $past(reg_rd_i)) else $error("read answer timing wrong");
  a_timeout_pulse: assert property (
    watchdog_timeout_o |=> !watchdog_timeout_o) else $error("timeout pulse too long");
  a_timeout_when_on: assert property (
    watchdog_timeout_o |-> $past(wdt_on)) else $error("timeout while disabled");
  a_status_follows: assert property (
    watchdog_timeout_o |-> watchdog_status_o) else $error("status missing on timeout");
  a_status_sticky: assert property (
    watchdog_status_o && !status_clear_i |=> watchdog_status_o) else $error("status dropped");
  a_crc_status_set: assert property (
    link_crc_error_i |=> crc_status_o) else $error("crc status not set");
  a_mode_spi_ignored: assert property (
    reg_wr_i && !reg_from_uart_i && reg_addr_i == OFS_ACCESS_PORT_SEL
    |-> ##2 $stable(uart_break_access_o)) else $error("mode changed from spi");
  a_mode_uart_write: assert property (
    reg_wr_i && reg_from_uart_i && reg_addr_i == OFS_ACCESS_PORT_SEL
    |-> ##2 uart_break_access_o == $past(reg_wdata_i[UART_MODE_BIT], 2))
    else $error("mode not written from uart");
  a_scratch_invert: assert property (
    reg_wr_i && port_ok && reg_addr_i == OFS_INVERT_SCRATCH ##1 !reg_wr_i
    ##1 reg_rd_i && port_ok && reg_addr_i == OFS_INVERT_SCRATCH
    |=> reg_rdata_o == ~$past(reg_wdata_i, 3)) else $error("scratch not inverted");
  a_lot_id_read: assert property (
    reg_rd_i && port_ok && reg_addr_i == OFS_LOT_ID_LOW |=> reg_rdata_o == lot_id_i)
    else $error("lot id read wrong");
  a_limit_held: assert property (
    !adc_done_i |-> ##2 $stable(limit_status_o)) else $error("limit status moved");
  a_alarm_action: assert property (
    alarm_trigger_o == (fault_action_o != ACT_NONE)) else $error("alarm and action differ");
endmodule : diag_wdt_checker

bind diag_watchdog_register_bank diag_wdt_checker diag_wdt_checker_inst (.*);

// [tb/reg_host_model.sv]
// Host controller model issuing register strobes over either port
`timescale 1ns/100ps
module reg_host_model (
  // Clock
  input  wire logic        clk_i,
  // Register strobes
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic             reg_from_uart_o,
  output logic [5:0]       reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  // Read answer
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_from_uart_o = 1'b0;
    reg_addr_o = 6'h00;
    reg_wdata_o = 16'h0000;
  end
  // One-cycle strobe; released lines show the inverse
  task automatic wr(input logic u, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_o        <= 1'b1;
    reg_from_uart_o <= u;
    reg_addr_o      <= a;
    reg_wdata_o     <= d;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic u, input logic [5:0] a, output logic [16:0] r);
    @(posedge clk_i);
    reg_rd_o        <= 1'b1;
    reg_from_uart_o <= u;
    reg_addr_o      <= a;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    r = {reg_rvalid_i, reg_rdata_i};
  endtask : rd
endmodule : reg_host_model

// [tb/diag_watchdog_register_bank_test.sv]
// Self-checking bench for the diagnostic watchdog register bank
`timescale 1ns/100ps
module diag_watchdog_register_bank_test;
  import diag_wdt_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
  logic          clk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_from_uart_i, reg_rvalid_o;
  logic          adc_done_i, timeout_fault_mask_i, link_crc_error_i, status_clear_i;
  logic          watchdog_status_o, crc_status_o, watchdog_timeout_o, uart_break_access_o;
  logic          alarm_trigger_o;
  logic [1:0]    adc_chan_i, link_fault_action_i;
  logic [1:0]    act [3];
  logic [5:0]    reg_addr_i, limit_status_o;
  logic [11:0]   adc_data_i;
  logic [15:0]   reg_wdata_i, reg_rdata_o, lot_id_i;
  fault_action_t fault_action_o;
  int            fails, num_checks, mode, ex, mx, mdl [64], ab [3], bl [3];

  reg_host_model reg_host_model_inst (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_from_uart_o(reg_from_uart_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
  diag_watchdog_register_bank diag_watchdog_register_bank_inst (
    .clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_from_uart_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .lot_id_i, .adc_done_i, .adc_chan_i, .adc_data_i,
    .link_fault_action_i, .input0_action_i(act[0]), .input1_action_i(act[1]),
    .temp_action_i(act[2]), .timeout_fault_mask_i, .link_crc_error_i, .status_clear_i,
    .watchdog_status_o, .crc_status_o, .watchdog_timeout_o, .limit_status_o,
    .uart_break_access_o, .fault_action_o, .alarm_trigger_o);

  // ==========================================================
  // Register model and bus tasks
  task automatic bw(input logic u, input logic [5:0] a, input logic [15:0] d);
    reg_host_model_inst.wr(u, a, d);
    if (a == OFS_ACCESS_PORT_SEL ? u : u == mode) begin
      case (a)
        OFS_WATCHDOG_CONTROL: mdl[a] = d & 16'h003F;
        OFS_INPUT0_LIMITS, OFS_INPUT1_LIMITS, OFS_DIE_TEMP_LIMITS: mdl[a] = d;
        OFS_ACCESS_PORT_SEL: mdl[a] = d & 16'h0001;
        OFS_INVERT_SCRATCH: mdl[a] = ~d & 16'hFFFF;
        default: ;
      endcase
      mode = mdl[OFS_ACCESS_PORT_SEL];
    end
  endtask : bw
  task automatic br(input logic u, input logic [5:0] a);
    logic [16:0] r;
    reg_host_model_inst.rd(u, a, r);
    ex = (a != OFS_ACCESS_PORT_SEL && u != mode) ? 0 : mdl[a];
    `CHK(r, {1'b1, ex[15:0]})
  endtask : br
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #200_000;
    fails++;
    wrap_up();
  end
  // ==========================================================
  // Scenarios
  initial begin
    logic [15:0] v;
    logic [11:0] d;
    int ch;
    void'($urandom(32'h2609_cb6c));
    rst_b_i = 1'b0;
    adc_done_i = 1'b0;
    adc_chan_i = 2'h0;
    adc_data_i = 12'h000;
    link_crc_error_i = 1'b0;
    status_clear_i = 1'b0;
    lot_id_i = $urandom;
    {timeout_fault_mask_i, act[0], act[1], act[2], link_fault_action_i} = $urandom;
    mdl[OFS_WATCHDOG_CONTROL] = 16'h0018;
    for (int i = 18; i < 21; i++) mdl[i] = 16'hFF00;
    mdl[OFS_INVERT_SCRATCH] = 16'hFFFF;
    mdl[OFS_LOT_ID_LOW] = lot_id_i;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 17; i < 26; i++) br(1'b0, 6'(i));
    v = $urandom;
    bw(1'b0, OFS_INVERT_SCRATCH, v);
    br(1'b0, OFS_INVERT_SCRATCH);
    bw(1'b0, OFS_LOT_ID_LOW, v);
    br(1'b0, OFS_LOT_ID_LOW);
    bw(1'b0, OFS_ACCESS_PORT_SEL, 16'hFFFF);
    br(1'b0, OFS_ACCESS_PORT_SEL);
    bw(1'b1, OFS_ACCESS_PORT_SEL, 16'hFFFF);
    br(1'b0, OFS_INVERT_SCRATCH);
    `CHK(uart_break_access_o, 1'b1)
    br(1'b1, OFS_INVERT_SCRATCH);
    bw(1'b1, OFS_ACCESS_PORT_SEL, 16'h0000);
    br(1'b1, OFS_ACCESS_PORT_SEL);
    `CHK(uart_break_access_o, 1'b0)
    for (int i = 0; i < 15; i++) begin
      ch = i % 3;
      v = $urandom;
      bw(1'b0, 6'(OFS_INPUT0_LIMITS + ch), v);
      case (i / 3)
        0: d = {v[15:8], 4'hF};
        1: d = {v[7:0], 4'h0};
        2: d = {v[7:0], 4'h0} - 12'h001;
        default: d = $urandom;
      endcase
      ab[ch] = d > v[15:8] * 16 + 15;
      bl[ch] = d < v[7:0] * 16;
      @(posedge clk_i);
      adc_done_i <= 1'b1;
      adc_chan_i <= 2'(ch);
      adc_data_i <= d;
      @(posedge clk_i);
      adc_done_i <= 1'b0;
      adc_data_i <= ~d;
      @(posedge clk_i);
      #1;
      ex = 0;
      mx = 0;
      for (int c = 0; c < 3; c++) begin
        ex = ex | (ab[c] << (2 * c)) | (bl[c] << (2 * c + 1));
        if ((ab[c] | bl[c]) != 0 && act[c] > mx) mx = act[c];
      end
      `CHK(limit_status_o, 6'(ex))
      `CHK({alarm_trigger_o, fault_action_o}, {mx != 0, 2'(mx)})
    end
    @(posedge clk_i);
    link_crc_error_i <= 1'b1;
    @(posedge clk_i);
    link_crc_error_i <= 1'b0;
    #1;
    `CHK(crc_status_o, 1'b1)
    @(posedge clk_i);
    status_clear_i <= 1'b1;
    @(posedge clk_i);
    status_clear_i <= 1'b0;
    #1;
    `CHK(crc_status_o, 1'b0)
    @(posedge clk_i);
    link_crc_error_i <= 1'b1;
    status_clear_i   <= 1'b1;
    @(posedge clk_i);
    link_crc_error_i <= 1'b0;
    status_clear_i   <= 1'b0;
    #1;
    `CHK(crc_status_o, 1'b1)
    bw(1'b0, OFS_WATCHDOG_CONTROL, 16'h001B);
    #1;
    `CHK(watchdog_timeout_o, 1'b0)
    bw(1'b0, OFS_WATCHDOG_CONTROL, 16'h001B);
    #1;
    `CHK({watchdog_timeout_o, watchdog_status_o}, 2'b11)
    bw(1'b1, OFS_ACCESS_PORT_SEL, 16'h0001);
    bw(1'b0, OFS_WATCHDOG_CONTROL, 16'h001B);
    #1;
    `CHK(watchdog_timeout_o, 1'b0)
    bw(1'b1, OFS_WATCHDOG_CONTROL, 16'h001B);
    #1;
    `CHK(watchdog_timeout_o, 1'b1)
    wrap_up();
  end
endmodule : diag_watchdog_register_bank_test
